/* rda_pkg.sv */
package rda_pkg;

    // ********************************************************************
    // clock and timing
    // ********************************************************************
    localparam int CLK_MHZ = 250;
    localparam int BRACKET_DELAY_NS = 20125;
    localparam int BRACKET_DELAY_CYC = BRACKET_DELAY_NS * CLK_MHZ / 1000;
    localparam int PRE_LEN_NS = 5000;
    localparam int PRE_LEN_CYC = PRE_LEN_NS * CLK_MHZ / 1000;
    localparam int PRE_TAP0_NS = 0;
    localparam int PRE_TAP1_NS = 1000;
    localparam int PRE_TAP2_NS = 3500;
    localparam int PRE_TAP3_NS = 4500;
    // shift index of each tap when the last preamble pulse is newest
    localparam int PRE_IDX0 = (PRE_TAP3_NS - PRE_TAP0_NS) * CLK_MHZ / 1000;
    localparam int PRE_IDX1 = (PRE_TAP3_NS - PRE_TAP1_NS) * CLK_MHZ / 1000;
    localparam int PRE_IDX2 = (PRE_TAP3_NS - PRE_TAP2_NS) * CLK_MHZ / 1000;
    localparam int PRE_IDX3 = 0;
    localparam int TOL_EARLY_PS = 62500;
    localparam int TOL_LATE_PS = 196500;
    localparam int TOL_EARLY_CYC = TOL_EARLY_PS * CLK_MHZ / 1000000;
    localparam int TOL_LATE_CYC = TOL_LATE_PS * CLK_MHZ / 1000000;
    localparam int MS_FIRST_NS = 3750;
    localparam int MS_BIT_NS = 1000;
    localparam int ATC_FIRST_NS = 1675;
    localparam int ATC_BIT_NS = 1450;
    localparam int MS_FIRST_CYC = MS_FIRST_NS * CLK_MHZ / 1000;
    localparam int MS_BIT_CYC = MS_BIT_NS * CLK_MHZ / 1000;
    localparam int ATC_FIRST_CYC = ATC_FIRST_NS * CLK_MHZ / 1000;
    localparam int ATC_BIT_CYC = ATC_BIT_NS * CLK_MHZ / 1000;
    localparam int ATTN_CYC = 2;

    // ********************************************************************
    // sizes and codes
    // ********************************************************************
    localparam int ADDR_CNT_W = 15;
    localparam logic [6:0] ATC_BITS = 7'h10;
    localparam logic [6:0] SHORT_BITS = 7'h38;
    localparam logic [6:0] LONG_BITS = 7'h70;
    localparam logic [3:0] BLOCK_WORDS = 4'hd;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int RANGE_W = 20;
    localparam int AZ_W = 14;
    localparam int AMP_W = 10;
    localparam logic [1:0] TYPE_ATC = 2'h0;
    localparam logic [1:0] TYPE_SHORT = 2'h1;
    localparam logic [1:0] TYPE_LONG = 2'h2;
    localparam int STAT_DIFF_BIT = 2;
    localparam int STAT_SIM_BIT = 3;
    localparam int REG_ADDR_W = 2;
    localparam logic [1:0] ADDR_FIFO = 2'h0;
    localparam logic [1:0] ADDR_STAT = 2'h1;
    localparam logic [1:0] ADDR_CTRL = 2'h2;
    localparam int CTRL_DIFF_BIT = 0;
    localparam int CTRL_SIM_BIT = 1;
    localparam int STAT_OVF_CLR_BIT = 15;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    typedef enum logic [3:0] {
        st_idle = 4'h0,
        st_rng_hi = 4'h2,
        st_rng_lo = 4'h3,
        st_az = 4'h4,
        st_wait_conv = 4'h5,
        st_sum = 4'h6,
        st_diff = 4'h7,
        st_wait_data = 4'h8,
        st_status = 4'h9,
        st_data = 4'ha,
        st_next = 4'hb,
        st_pad = 4'hc,
        st_attn = 4'hd
    } rda_state_type;

endpackage

/* rda_reader.sv */
`timescale 1ns/100ps
module rda_reader (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output logic [1:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        {addr_o, wdata_o, wr_o, rd_o} = '0;
    end
    // one access; read data taken at the edge closing the answer cycle
    task automatic acc(input logic w, input logic [1:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= !w;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        @(posedge clk_i);
        q = rdata_i;
    endtask
endmodule

/* rda_reply_assembler.sv */
`timescale 1ns/100ps
// Overview of operation
// RULE_01: bracket when new edge meets delayed pulse
// RULE_02: preamble when edges at four taps together
// RULE_03: other taps windowed, one microsecond tap exact
// RULE_04: bracket or preamble sets reply in progress
// RULE_05: address zero when idle, else counts every clock
// RULE_06: table by address picks sample commands per mode
// RULE_07: preamble start selects mode s sequence
// RULE_08: first mode s bit sets long flag
// RULE_09: reply end clears all three sampling flags
// RULE_10: sixteen bit shifter with load bit counter
// RULE_11: thirteen words per reply block
// RULE_12: register and buffer widths as sized
// RULE_13: one source word onto buffer at once
// RULE_14: range and azimuth captured on detect
// RULE_15: amplitudes and phase captured on converter ready
// RULE_16: four status bits: type, diff, simulated
// RULE_17: status captured with first data word
// RULE_18: data register loads shifter on data ready
// RULE_19: idle, then states two to four write position
// RULE_20: state five waits converter, six seven amplitudes
// RULE_21: state eight clears phase and converter flag
// RULE_22: wait data, status, data, repeat until end
// RULE_23: pad buffer to thirteen words after end
// RULE_24: two clock attention pulse after block
// RULE_25: delays and windows as whole clock counts
module rda_reply_assembler #(
    parameter int BRACKET_DELAY = rda_pkg::BRACKET_DELAY_CYC,
    parameter int PRE_LEN = rda_pkg::PRE_LEN_CYC,
    parameter int FIFO_DEPTH = rda_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic quantized_sum_n_i,
    input wire logic [rda_pkg::RANGE_W-1:0] range_cnt_i,
    input wire logic [rda_pkg::AZ_W-1:0] azimuth_cnt_i,
    input wire logic [rda_pkg::AMP_W-1:0] amp_sum_i,
    input wire logic [rda_pkg::AMP_W-1:0] amp_diff_i,
    input wire logic phase_bit_i,
    input wire logic conv_ready_i,
    input wire logic [rda_pkg::REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [rda_pkg::WORD_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [rda_pkg::WORD_W-1:0] reg_rdata_o,
    output logic reply_start_pulse_o,
    output logic block_attention_pulse_o,
    output logic parity_long_o,
    output logic diff_omni_sel_o
);

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int W = rda_pkg::WORD_W;
    localparam int AW = rda_pkg::ADDR_CNT_W;

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic q_s1;
        logic q_s2;
        logic pulse_prev;
        logic rdy_s1;
        logic rdy_s2;
        logic rdy_prev;
        logic ph_s1;
        logic ph_s2;
        logic [2*rda_pkg::AMP_W-1:0] amp_s1;
        logic [2*rda_pkg::AMP_W-1:0] amp_s2;
        logic [BRACKET_DELAY-1:0] dly;
        logic [PRE_LEN-1:0] pre;
        logic in_prog;
        logic mode_s;
        logic long_f;
        logic [AW-1:0] addr;
        logic [6:0] bits;
        logic [W-1:0] shifter;
        logic [4:0] load_cnt;
        logic data_rdy;
        logic end_seen;
        logic first_word;
        logic [rda_pkg::RANGE_W-1:0] range;
        logic [rda_pkg::AZ_W-1:0] az;
        logic [rda_pkg::AMP_W-1:0] sum;
        logic [rda_pkg::AMP_W-1:0] diff;
        logic phase;
        logic conv_flag;
        logic [3:0] status;
        logic [W-1:0] data;
        rda_pkg::rda_state_type state;
        logic [3:0] words;
        logic attn_cnt;
        logic [FIFO_DEPTH-1:0][W-1:0] fifo;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
        logic overflow;
        logic [1:0] ctrl;
        logic [W-1:0] rd_data;
        logic start_pulse;
        logic attn;
    } rda_regs_type;

    rda_regs_type s_q;
    rda_regs_type s_d;

    // any edge in the tap window around idx
    function automatic logic win_hit(input logic [PRE_LEN-1:0] v, input int idx);
        logic hit;
        hit = 1'b0;
        for (int i = idx - rda_pkg::TOL_LATE_CYC; i <= idx + rda_pkg::TOL_EARLY_CYC; i++) begin
            if (i >= 0 && i < PRE_LEN && v[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // command table: sample strobe for a sampling address in either mode
    function automatic logic samp_hit(input logic ms, input logic [AW-1:0] a);
        int first;
        int per;
        int ai;
        first = ms ? rda_pkg::MS_FIRST_CYC : rda_pkg::ATC_FIRST_CYC;
        per = ms ? rda_pkg::MS_BIT_CYC : rda_pkg::ATC_BIT_CYC;
        ai = int'(a);
        return (ai >= first) && (((ai - first) % per) == 0);
    endfunction

    logic pulse;
    logic edge_det;
    logic delayed;
    logic bracket;
    logic preamble;
    logic detect;
    logic reply_end;
    logic conv_rise;

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        logic bit_v;
        logic [6:0] bits_n;
        logic [6:0] end_bits;
        logic [4:0] ld_n;
        logic [W-1:0] sh_n;
        logic long_n;
        logic push;
        logic pop;
        logic [W-1:0] wdata;
        logic rdy_set;
        bit_v = 1'b0;
        bits_n = 7'h0;
        end_bits = 7'h0;
        ld_n = 5'h0;
        sh_n = '0;
        long_n = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        wdata = '0;
        rdy_set = 1'b0;
        s_d = s_q;
        reply_end = 1'b0;

        // pin synchronisers
        s_d.q_s1 = quantized_sum_n_i;
        s_d.q_s2 = s_q.q_s1;
        s_d.rdy_s1 = conv_ready_i;
        s_d.rdy_s2 = s_q.rdy_s1;
        s_d.ph_s1 = phase_bit_i;
        s_d.ph_s2 = s_q.ph_s1;
        s_d.amp_s1 = {amp_sum_i, amp_diff_i};
        s_d.amp_s2 = s_q.amp_s1;

        pulse = ~s_q.q_s2;
        edge_det = pulse & ~s_q.pulse_prev;
        s_d.pulse_prev = pulse;
        delayed = s_q.dly[BRACKET_DELAY-1];
        s_d.dly = {s_q.dly[BRACKET_DELAY-2:0], pulse};                  // [RULE_01] [RULE_25]
        s_d.pre = {s_q.pre[PRE_LEN-2:0], edge_det};                     // [RULE_02] [RULE_25]
        bracket = edge_det & delayed;                                   // [RULE_01]
        preamble = win_hit(s_q.pre, rda_pkg::PRE_IDX0)                  // [RULE_03]
            & s_q.pre[rda_pkg::PRE_IDX1]
            & win_hit(s_q.pre, rda_pkg::PRE_IDX2)
            & win_hit(s_q.pre, rda_pkg::PRE_IDX3);                      // [RULE_02]
        detect = (bracket | preamble) & ~s_q.in_prog;
        s_d.start_pulse = detect;

        // ****************************************************************
        // data sampling controller
        // ****************************************************************
        if (detect) begin
            s_d.in_prog = 1'b1;                                         // [RULE_04]
            s_d.mode_s = preamble;                                      // [RULE_07]
            s_d.range = range_cnt_i;                                    // [RULE_14]
            s_d.az = azimuth_cnt_i;                                     // [RULE_14]
            s_d.addr = '0;
            s_d.bits = 7'h0;
            s_d.load_cnt = 5'h0;
            s_d.first_word = 1'b1;
            s_d.end_seen = 1'b0;
        end else if (s_q.in_prog) begin
            s_d.addr = s_q.addr + AW'(1);                               // [RULE_05]
            if (samp_hit(s_q.mode_s, s_q.addr)) begin                   // [RULE_06]
                bit_v = s_q.mode_s ? pulse : delayed;
                sh_n = {s_q.shifter[W-2:0], bit_v};                     // [RULE_10]
                s_d.shifter = sh_n;
                bits_n = s_q.bits + 7'h1;
                s_d.bits = bits_n;
                long_n = (s_q.mode_s && s_q.bits == 7'h0) ? bit_v : s_q.long_f;
                s_d.long_f = long_n;                                    // [RULE_08]
                end_bits = !s_q.mode_s ? rda_pkg::ATC_BITS
                    : (long_n ? rda_pkg::LONG_BITS : rda_pkg::SHORT_BITS); // [RULE_08]
                reply_end = (bits_n == end_bits);
                ld_n = s_q.load_cnt + 5'h1;                             // [RULE_10]
                s_d.load_cnt = ld_n;
                if (ld_n == 5'h10 || reply_end) begin
                    s_d.data = sh_n << (5'h10 - ld_n);                  // [RULE_18]
                    s_d.data_rdy = 1'b1;
                    rdy_set = 1'b1;
                    s_d.load_cnt = 5'h0;
                    if (s_q.first_word) begin
                        s_d.first_word = 1'b0;
                        s_d.status[1:0] = !s_q.mode_s ? rda_pkg::TYPE_ATC
                            : (long_n ? rda_pkg::TYPE_LONG : rda_pkg::TYPE_SHORT); // [RULE_16]
                        s_d.status[rda_pkg::STAT_DIFF_BIT] = s_q.ctrl[rda_pkg::CTRL_DIFF_BIT];
                        s_d.status[rda_pkg::STAT_SIM_BIT] = s_q.ctrl[rda_pkg::CTRL_SIM_BIT]; // [RULE_17]
                    end
                end
            end
            if (reply_end) begin
                s_d.in_prog = 1'b0;                                     // [RULE_09]
                s_d.mode_s = 1'b0;
                s_d.long_f = 1'b0;
                s_d.addr = '0;
                s_d.end_seen = 1'b1;
            end
        end else begin
            s_d.addr = '0;                                              // [RULE_05]
        end

        // ****************************************************************
        // reply assembler state controller
        // ****************************************************************
        conv_rise = s_q.rdy_s2 & ~s_q.rdy_prev;
        s_d.rdy_prev = s_q.rdy_s2;
        case (s_q.state)
            rda_pkg::st_idle: begin
                if (s_q.start_pulse) begin
                    s_d.state = rda_pkg::st_rng_hi;                     // [RULE_19]
                end
            end
            rda_pkg::st_rng_hi: begin
                push = 1'b1;
                wdata = {{(2 * W - rda_pkg::RANGE_W){1'b0}}, s_q.range[rda_pkg::RANGE_W-1:W]};
                s_d.state = rda_pkg::st_rng_lo;
            end
            rda_pkg::st_rng_lo: begin
                push = 1'b1;
                wdata = s_q.range[W-1:0];
                s_d.state = rda_pkg::st_az;
            end
            rda_pkg::st_az: begin
                push = 1'b1;
                wdata = {{(W - rda_pkg::AZ_W){1'b0}}, s_q.az};         // [RULE_19]
                s_d.state = rda_pkg::st_wait_conv;
            end
            rda_pkg::st_wait_conv: begin
                if (s_q.conv_flag) begin
                    s_d.state = rda_pkg::st_sum;                        // [RULE_20]
                end
            end
            rda_pkg::st_sum: begin
                push = 1'b1;
                wdata = {{(W - rda_pkg::AMP_W - 1){1'b0}}, s_q.phase, s_q.sum};
                s_d.state = rda_pkg::st_diff;
            end
            rda_pkg::st_diff: begin
                push = 1'b1;
                wdata = {{(W - rda_pkg::AMP_W){1'b0}}, s_q.diff};       // [RULE_20]
                s_d.state = rda_pkg::st_wait_data;
            end
            rda_pkg::st_wait_data: begin
                s_d.phase = 1'b0;                                       // [RULE_21]
                s_d.conv_flag = 1'b0;                                   // [RULE_21]
                if (s_q.data_rdy) begin
                    s_d.state = rda_pkg::st_status;                     // [RULE_22]
                end
            end
            rda_pkg::st_status: begin
                push = 1'b1;
                wdata = {{(W - 4){1'b0}}, s_q.status};
                s_d.state = rda_pkg::st_data;
            end
            rda_pkg::st_data: begin
                push = 1'b1;
                wdata = s_q.data;
                // a word completed in this very cycle keeps its ready flag
                if (!rdy_set) begin
                    s_d.data_rdy = 1'b0;
                end
                s_d.state = s_q.end_seen ? rda_pkg::st_pad : rda_pkg::st_next; // [RULE_22]
            end
            rda_pkg::st_next: begin
                if (s_q.data_rdy) begin
                    s_d.state = rda_pkg::st_data;                       // [RULE_22]
                end
            end
            rda_pkg::st_pad: begin
                if (s_q.words == rda_pkg::BLOCK_WORDS) begin
                    s_d.attn = 1'b1;                                    // [RULE_24]
                    s_d.attn_cnt = 1'b0;
                    s_d.state = rda_pkg::st_attn;
                end else begin
                    push = 1'b1;                                        // [RULE_23]
                end
            end
            rda_pkg::st_attn: begin
                s_d.attn_cnt = 1'b1;
                if (s_q.attn_cnt == 1'(rda_pkg::ATTN_CYC - 1)) begin
                    s_d.attn = 1'b0;                                    // [RULE_24]
                    s_d.state = rda_pkg::st_idle;
                end
            end
            default: begin
                s_d.state = rda_pkg::st_idle;
            end
        endcase
        if (s_q.state == rda_pkg::st_idle) begin
            s_d.words = 4'h0;
        end else if (push) begin
            s_d.words = s_q.words + 4'h1;                               // [RULE_11]
        end

        // converter capture after the state controller so a new result wins
        if (conv_rise) begin
            s_d.sum = s_q.amp_s2[2*rda_pkg::AMP_W-1:rda_pkg::AMP_W];    // [RULE_15]
            s_d.diff = s_q.amp_s2[rda_pkg::AMP_W-1:0];                  // [RULE_15]
            s_d.phase = s_q.ph_s2;
            s_d.conv_flag = 1'b1;
        end

        // ****************************************************************
        // register port and output buffer
        // ****************************************************************
        s_d.rd_data = '0;
        if (reg_wr_i && reg_addr_i == rda_pkg::ADDR_CTRL) begin
            s_d.ctrl = reg_wdata_i[1:0];
        end
        if (reg_wr_i && reg_addr_i == rda_pkg::ADDR_STAT
            && reg_wdata_i[rda_pkg::STAT_OVF_CLR_BIT]) begin
            s_d.overflow = 1'b0;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                rda_pkg::ADDR_FIFO: begin
                    if (s_q.count != '0) begin
                        s_d.rd_data = s_q.fifo[s_q.rd_ptr];
                        s_d.rd_ptr = s_q.rd_ptr + PTR_W'(1);
                        pop = 1'b1;
                    end
                end
                rda_pkg::ADDR_STAT: begin
                    s_d.rd_data = W'({s_q.overflow, s_q.in_prog, s_q.mode_s, s_q.long_f,
                        s_q.state, 3'h0, s_q.count});
                end
                rda_pkg::ADDR_CTRL: begin
                    s_d.rd_data = {{(W - 2){1'b0}}, s_q.ctrl};
                end
                default: begin
                    s_d.rd_data = '0;
                end
            endcase
        end
        if (push) begin
            if (s_q.count < (PTR_W + 1)'(FIFO_DEPTH)) begin
                s_d.fifo[s_q.wr_ptr] = wdata;                           // [RULE_13] [RULE_12]
                s_d.wr_ptr = s_q.wr_ptr + PTR_W'(1);
            end else begin
                push = 1'b0;
                s_d.overflow = 1'b1;
            end
        end
        s_d.count = s_q.count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
            s_q.q_s1 <= 1'b1;
            s_q.q_s2 <= 1'b1;
            s_q.ctrl <= rda_pkg::CTRL_RESET;
            s_q.state <= rda_pkg::st_idle;                              // [RULE_19]
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o = s_q.rd_data;
    assign reply_start_pulse_o = s_q.start_pulse;
    assign block_attention_pulse_o = s_q.attn;
    assign parity_long_o = s_q.long_f;
    assign diff_omni_sel_o = s_q.ctrl[rda_pkg::CTRL_DIFF_BIT];

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    addr_idle_a: assert property (!s_q.in_prog |-> s_q.addr == '0) // [RULE_05]
        else $error("sampling address not zero while idle");
    addr_count_a: assert property (s_q.in_prog && !reply_end |=> // [RULE_05]
        s_q.addr == $past(s_q.addr) + AW'(1))
        else $error("sampling address did not step");
    start_sets_a: assert property (detect |=> s_q.in_prog && s_q.start_pulse) // [RULE_04]
        else $error("detect did not start sampling");
    mode_select_a: assert property (detect |=> s_q.mode_s == $past(preamble)) // [RULE_07]
        else $error("mode flag does not follow detect source");
    end_clears_a: assert property (reply_end |=> // [RULE_09]
        !s_q.in_prog && !s_q.mode_s && !s_q.long_f && s_q.addr == '0)
        else $error("reply end left sampling flags set");
    range_capture_a: assert property (detect |=> // [RULE_14]
        s_q.range == $past(range_cnt_i) && s_q.az == $past(azimuth_cnt_i))
        else $error("position not captured at detect");
    conv_clear_a: assert property (s_q.state == rda_pkg::st_wait_data && !conv_rise // [RULE_21]
        |=> !s_q.conv_flag && !s_q.phase)
        else $error("converter flag survived wait state");
    idle_leave_a: assert property (s_q.state == rda_pkg::st_idle && s_q.start_pulse // [RULE_19]
        |=> s_q.state == rda_pkg::st_rng_hi ##1 s_q.state == rda_pkg::st_rng_lo
        ##1 s_q.state == rda_pkg::st_az)
        else $error("position words not written in order");
    block_size_a: assert property ($rose(s_q.attn) |-> s_q.words == rda_pkg::BLOCK_WORDS) // [RULE_11]
        else $error("block not thirteen words");
    attn_width_a: assert property ($rose(s_q.attn) |-> s_q.attn [*2] ##1 !s_q.attn) // [RULE_24]
        else $error("attention pulse not two clocks");
    wait_conv_a: assert property (s_q.state == rda_pkg::st_wait_conv && !s_q.conv_flag // [RULE_20]
        |=> s_q.state == rda_pkg::st_wait_conv)
        else $error("left state five without converter ready");

    bracket_c: cover property (bracket && !s_q.in_prog);
    preamble_c: cover property (preamble && !s_q.in_prog);
    long_reply_c: cover property (reply_end && s_q.long_f);
    block_done_c: cover property ($rose(s_q.attn));

endmodule

/* reply_detect_and_assemble_bench.sv */
`timescale 1ns/100ps
module reply_detect_and_assemble_bench;
    logic clk, rst_n, vid_n, conv, ph, wr, rd, spulse, attn, plong, dsel;
    logic [1:0] addr;
    logic [15:0] wdata, rdata, q;
    logic [15:0] exp_w [13];
    int n_mismatch, checks, n;
    rda_reader rdr (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    rda_reply_assembler #(.BRACKET_DELAY(40)) DUT (.ref_clk_i(clk), .reset_n_i(rst_n),
        .quantized_sum_n_i(vid_n), .range_cnt_i(20'h5a3c1), .azimuth_cnt_i(14'h2bcd),
        .amp_sum_i(10'h2a5), .amp_diff_i(10'h15a), .phase_bit_i(ph), .conv_ready_i(conv),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reply_start_pulse_o(spulse), .block_attention_pulse_o(attn),
        .parity_long_o(plong), .diff_omni_sel_o(dsel));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
        checks++;
        if (seen !== ex) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // idle gap, then one video pulse of given width
    task automatic pls(input int gap, input int len);
        repeat (gap) @(posedge clk);
        vid_n <= 1'b0;
        repeat (len) @(posedge clk);
        vid_n <= 1'b1;
    endtask
    // ********************************************************************
    // block check: converter event, attention, then 13 words in order
    // ********************************************************************
    task automatic reply(input logic [1:0] ty, input logic [15:0] d0, input logic p);
        ph <= p;
        repeat (60) @(posedge clk);
        conv <= 1'b1;
        repeat (10) @(posedge clk);
        conv <= 1'b0;
        exp_w = '{default: 16'h0};
        exp_w[0] = 16'h0005;
        exp_w[1] = 16'ha3c1;
        exp_w[2] = 16'h2bcd;
        exp_w[3] = {5'h0, p, 10'h2a5};
        exp_w[4] = 16'h015a;
        exp_w[5] = {12'h0, 2'h3, ty};
        exp_w[6] = d0;
        n = 0;
        while (attn !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        if (n == 40000) begin
            n_mismatch++;
            close_out();
        end
        n = 0;
        while (attn === 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk("attn width", 16'(n), 16'h2);
        rdr.acc(1'b0, 2'h1, 16'h0, q);
        chk("word count", {11'h0, q[4:0]}, 16'hd);
        chk("idle state", {12'h0, q[11:8]}, 16'h0);
        for (int i = 0; i < 13; i++) begin
            rdr.acc(1'b0, 2'h0, 16'h0, q);
            chk("block word", q, exp_w[i]);
        end
        rdr.acc(1'b0, 2'h0, 16'h0, q);
        chk("empty read", q, 16'h0);
    endtask
    initial begin
        {vid_n, conv, ph, rst_n, n_mismatch, checks} = {2'b10, 2'b00, 32'd0, 32'd0};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset outs", {12'h0, spulse, attn, plong, dsel}, 16'h0);
        rdr.acc(1'b0, 2'h3, 16'h0, q);
        chk("unmapped", q, 16'h0);
        rdr.acc(1'b1, 2'h2, 16'h3, q);
        chk("diff sel", {15'h0, dsel}, 16'h1);
        pls(5, 100);
        pls(150, 100);
        pls(525, 100);
        pls(150, 100);
        // pulse over the first mode s bit makes the reply long
        pls(700, 300);
        chk("long flag", {15'h0, plong}, 16'h1);
        reply(2'h2, 16'h8000, 1'b1);
        chk("long cleared", {15'h0, plong}, 16'h0);
        pls(5, 10);
        pls(30, 10);
        reply(2'h0, 16'h0, 1'b0);
        close_out();
    end
endmodule
